// *** arch_state_pkg.sv ***
package arch_state_pkg;

  localparam int XLEN = 32;
  localparam int GPR_COUNT = 16;
  localparam int GPR_IDX_W = 4;
  localparam int LEVEL_W = 5;
  localparam int BUS_ADDR_W = 4;

  // Implicit roles of the top three general registers.
  localparam logic [3:0] GPR_VIRTUAL_ACC = 4'hd;
  localparam logic [3:0] GPR_FRAME_PTR = 4'he;
  localparam logic [3:0] GPR_STACK_PTR = 4'hf;

  // Register port word indices.
  localparam logic [3:0] REG_INSTRUCTION_POINTER = 4'h0;
  localparam logic [3:0] REG_PROGRAM_STATUS = 4'h1;
  localparam logic [3:0] REG_VECTOR_TABLE_BASE = 4'h2;
  localparam logic [3:0] REG_RETURN_POINTER = 4'h3;
  localparam logic [3:0] REG_SYSTEM_STACK = 4'h4;
  localparam logic [3:0] REG_USER_STACK = 4'h5;
  localparam logic [3:0] REG_MULDIV_HIGH = 4'h6;
  localparam logic [3:0] REG_MULDIV_LOW = 4'h7;
  localparam logic [3:0] REG_LEVEL_MASK = 4'h8;

  // Program status field positions.
  localparam int PS_CARRY = 0;
  localparam int PS_OVERFLOW = 1;
  localparam int PS_ZERO = 2;
  localparam int PS_NEGATIVE = 3;
  localparam int PS_IRQ_PERMIT = 4;
  localparam int PS_STACK_SELECT = 5;
  localparam int PS_STEP_TRACE = 8;
  localparam int PS_LEVEL_LSB = 16;
  localparam int PS_LEVEL_MSB = 20;
  localparam logic [31:0] PS_WRITABLE = 32'h001f013f;

  // Reset values.
  localparam logic [31:0] PS_RESET = 32'h000f0000;
  localparam logic [31:0] STACK_RESET = 32'h00000000;
  localparam logic [31:0] VECTOR_BASE_RESET = 32'h000ffc00;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  // Direct addressing limits per access size.
  localparam logic [31:0] DIRECT_BYTE_LIMIT = 32'h000000ff;
  localparam logic [31:0] DIRECT_HALF_LIMIT = 32'h000001ff;
  localparam logic [31:0] DIRECT_WORD_LIMIT = 32'h000003ff;
  localparam int DIRECT_FIELD_W = 8;

  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_HALF,
    SIZE_WORD
  } access_size_type;

  typedef struct packed {
    logic update;
    logic [31:0] result;
    logic carry;
    logic overflow;
  } alu_flags_type;

  typedef struct packed {
    logic enable;
    logic [3:0] index;
    logic [31:0] data;
  } gpr_write_type;

  typedef struct packed {
    logic enable;
    logic [31:0] high;
    logic [31:0] low;
  } muldiv_write_type;

endpackage

// *** cpu_arch_state.sv ***
`timescale 1ns/1ps
module cpu_arch_state #(
  parameter int GPR_NUM = 16,
  parameter logic [31:0] IP_RESET = 32'h00000000
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [3:0] read_a_index,
  input wire logic [3:0] read_b_index,
  output logic [31:0] read_a_data,
  output logic [31:0] read_b_data,
  input wire arch_state_pkg::gpr_write_type gpr_write,
  input wire logic ip_load,
  input wire logic [31:0] ip_next,
  input wire logic rp_load,
  input wire logic [31:0] rp_next,
  input wire arch_state_pkg::alu_flags_type alu_flags,
  input wire arch_state_pkg::muldiv_write_type muldiv_write,
  input wire logic [7:0] direct_field,
  input wire arch_state_pkg::access_size_type direct_size,
  output logic [31:0] direct_addr,
  output logic direct_in_range,
  input wire logic instr_retire,
  output logic trace_trap,
  input wire logic irq_req,
  input wire logic [4:0] irq_level,
  output logic irq_accept,
  output logic [31:0] instruction_pointer,
  output logic [31:0] vector_table_base,
  output logic [31:0] return_pointer,
  output logic [31:0] program_status
);

  //////////////////////////////////////////////////////////////////////////////

  if (GPR_NUM != arch_state_pkg::GPR_COUNT) begin : g_bad_count
    $error("cpu_arch_state supports exactly sixteen general registers");
  end

  logic [31:0] gpr_q [0:14];
  logic [31:0] ip_q;
  logic [31:0] ps_q;
  logic [31:0] vtb_q;
  logic [31:0] rp_q;
  logic [31:0] ssp_q;
  logic [31:0] usp_q;
  logic [31:0] mdh_q;
  logic [31:0] mdl_q;
  logic [31:0] rdata_q;
  logic [31:0] read_a_q;
  logic [31:0] read_b_q;
  logic [31:0] dir_addr_q;
  logic dir_ok_q;
  logic trace_q;
  logic [31:0] ps_d;
  logic [31:0] dir_addr_d;
  logic stack_sel;
  logic [4:0] level_mask;
  logic bus_wr_ps;
  logic bus_wr_ilm;

  assign stack_sel = ps_q[arch_state_pkg::PS_STACK_SELECT];
  assign level_mask = ps_q[arch_state_pkg::PS_LEVEL_MSB:arch_state_pkg::PS_LEVEL_LSB];
  assign bus_wr_ps = reg_wr && reg_addr == arch_state_pkg::REG_PROGRAM_STATUS;
  assign bus_wr_ilm = reg_wr && reg_addr == arch_state_pkg::REG_LEVEL_MASK;

  // Register 15 resolves to whichever stack pointer the select flag names.
  function automatic logic [31:0] gpr_read(input logic [3:0] idx, input logic sel,
                                           input logic [31:0] system_stack_pointer, input logic [31:0] user_stack_pointer,
                                           input logic [31:0] low_value);
    if (idx == arch_state_pkg::GPR_STACK_PTR) begin
      gpr_read = sel ? user_stack_pointer : system_stack_pointer;
    end else begin
      gpr_read = low_value;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // General registers 0 to 14 carry no reset, so their power-up value is free.

  always_ff @(posedge clk) begin
    if (gpr_write.enable && gpr_write.index != arch_state_pkg::GPR_STACK_PTR) begin
      gpr_q[gpr_write.index] <= gpr_write.data;
    end
  end

  always_ff @(posedge clk) begin
    read_a_q <= gpr_read(read_a_index, stack_sel, ssp_q, usp_q,
                         gpr_q[read_a_index[3] && read_a_index[2:0] == 3'h7 ? 4'h0 : read_a_index]);
    read_b_q <= gpr_read(read_b_index, stack_sel, ssp_q, usp_q,
                         gpr_q[read_b_index[3] && read_b_index[2:0] == 3'h7 ? 4'h0 : read_b_index]);
  end

  assign read_a_data = read_a_q;
  assign read_b_data = read_b_q;

  //////////////////////////////////////////////////////////////////////////////
  // Stack pointers: the register port has priority over a pipeline write.

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ssp_q <= arch_state_pkg::STACK_RESET;
    end else if (reg_wr && reg_addr == arch_state_pkg::REG_SYSTEM_STACK) begin
      ssp_q <= reg_wdata;
    end else if (gpr_write.enable && gpr_write.index == arch_state_pkg::GPR_STACK_PTR && !stack_sel) begin
      ssp_q <= gpr_write.data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      usp_q <= arch_state_pkg::STACK_RESET;
    end else if (reg_wr && reg_addr == arch_state_pkg::REG_USER_STACK) begin
      usp_q <= reg_wdata;
    end else if (gpr_write.enable && gpr_write.index == arch_state_pkg::GPR_STACK_PTR && stack_sel) begin
      usp_q <= gpr_write.data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Dedicated registers.

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ip_q <= IP_RESET;
    end else if (reg_wr && reg_addr == arch_state_pkg::REG_INSTRUCTION_POINTER) begin
      ip_q <= reg_wdata;
    end else if (ip_load) begin
      ip_q <= ip_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vtb_q <= arch_state_pkg::VECTOR_BASE_RESET;
    end else if (reg_wr && reg_addr == arch_state_pkg::REG_VECTOR_TABLE_BASE) begin
      vtb_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rp_q <= arch_state_pkg::WORD_ZERO;
    end else if (reg_wr && reg_addr == arch_state_pkg::REG_RETURN_POINTER) begin
      rp_q <= reg_wdata;
    end else if (rp_load) begin
      rp_q <= rp_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mdh_q <= arch_state_pkg::WORD_ZERO;
      mdl_q <= arch_state_pkg::WORD_ZERO;
    end else if (muldiv_write.enable) begin
      mdh_q <= muldiv_write.high;
      mdl_q <= muldiv_write.low;
    end else if (reg_wr && reg_addr == arch_state_pkg::REG_MULDIV_HIGH) begin
      mdh_q <= reg_wdata;
    end else if (reg_wr && reg_addr == arch_state_pkg::REG_MULDIV_LOW) begin
      mdl_q <= reg_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Program status: flag updates from the ALU, overridden by a port write.

  always_comb begin
    ps_d = ps_q;
    if (alu_flags.update) begin
      ps_d[arch_state_pkg::PS_NEGATIVE] = alu_flags.result[31];
      ps_d[arch_state_pkg::PS_ZERO] = alu_flags.result == arch_state_pkg::WORD_ZERO;
      ps_d[arch_state_pkg::PS_OVERFLOW] = alu_flags.overflow;
      ps_d[arch_state_pkg::PS_CARRY] = alu_flags.carry;
    end
    if (bus_wr_ps) begin
      ps_d = reg_wdata & arch_state_pkg::PS_WRITABLE;
    end else if (bus_wr_ilm) begin
      ps_d[arch_state_pkg::PS_LEVEL_MSB:arch_state_pkg::PS_LEVEL_LSB] = reg_wdata[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ps_q <= arch_state_pkg::PS_RESET;
    end else begin
      ps_q <= ps_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt acceptance and step trace.

  assign irq_accept = irq_req && ps_q[arch_state_pkg::PS_IRQ_PERMIT]
                      && irq_level < level_mask;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trace_q <= 1'b0;
    end else begin
      trace_q <= instr_retire && ps_q[arch_state_pkg::PS_STEP_TRACE];
    end
  end

  assign trace_trap = trace_q;

  //////////////////////////////////////////////////////////////////////////////
  // Direct addressing: field scaled by access size, never read from a register.

  always_comb begin
    dir_addr_d = {24'h000000, direct_field};
    if (direct_size == arch_state_pkg::SIZE_HALF) begin
      dir_addr_d = {23'h0, direct_field, 1'b0};
    end else if (direct_size == arch_state_pkg::SIZE_WORD) begin
      dir_addr_d = {22'h0, direct_field, 2'h0};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dir_addr_q <= arch_state_pkg::WORD_ZERO;
      dir_ok_q <= 1'b0;
    end else begin
      dir_addr_q <= dir_addr_d;
      unique case (direct_size)
        arch_state_pkg::SIZE_BYTE: dir_ok_q <= dir_addr_d <= arch_state_pkg::DIRECT_BYTE_LIMIT;
        arch_state_pkg::SIZE_HALF: dir_ok_q <= dir_addr_d <= arch_state_pkg::DIRECT_HALF_LIMIT;
        arch_state_pkg::SIZE_WORD: dir_ok_q <= dir_addr_d <= arch_state_pkg::DIRECT_WORD_LIMIT;
        default: dir_ok_q <= 1'b0;
      endcase
    end
  end

  assign direct_addr = dir_addr_q;
  assign direct_in_range = dir_ok_q;

  //////////////////////////////////////////////////////////////////////////////
  // Register port read: data one cycle after the strobe, zero when unmapped.

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= arch_state_pkg::WORD_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        arch_state_pkg::REG_INSTRUCTION_POINTER: rdata_q <= ip_q;
        arch_state_pkg::REG_PROGRAM_STATUS: rdata_q <= ps_q;
        arch_state_pkg::REG_VECTOR_TABLE_BASE: rdata_q <= vtb_q;
        arch_state_pkg::REG_RETURN_POINTER: rdata_q <= rp_q;
        arch_state_pkg::REG_SYSTEM_STACK: rdata_q <= ssp_q;
        arch_state_pkg::REG_USER_STACK: rdata_q <= usp_q;
        arch_state_pkg::REG_MULDIV_HIGH: rdata_q <= mdh_q;
        arch_state_pkg::REG_MULDIV_LOW: rdata_q <= mdl_q;
        arch_state_pkg::REG_LEVEL_MASK: rdata_q <= {27'h0, level_mask};
        default: rdata_q <= arch_state_pkg::WORD_ZERO;
      endcase
    end else begin
      rdata_q <= arch_state_pkg::WORD_ZERO;
    end
  end

  assign reg_rdata = rdata_q;
  assign instruction_pointer = ip_q;
  assign vector_table_base = vtb_q;
  assign return_pointer = rp_q;
  assign program_status = ps_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_stack_select_read: assert property (
    @(posedge clk) disable iff (sys_rst)
    read_a_index == arch_state_pkg::GPR_STACK_PTR |=>
      read_a_data == ($past(stack_sel) ? $past(usp_q) : $past(ssp_q)))
    else $error("register 15 read did not follow the stack select flag");

  a_stack_write_steer: assert property (
    @(posedge clk) disable iff (sys_rst)
    gpr_write.enable && gpr_write.index == arch_state_pkg::GPR_STACK_PTR && !reg_wr |=>
      ($past(stack_sel) ? usp_q : ssp_q) == $past(gpr_write.data))
    else $error("register 15 write reached the wrong stack pointer");

  a_reset_stack_zero: assert property (
    @(posedge clk) $past(sys_rst) && !sys_rst |-> ssp_q == arch_state_pkg::STACK_RESET && !stack_sel)
    else $error("register 15 is not zero after reset");

  a_zero_neg_flags: assert property (
    @(posedge clk) disable iff (sys_rst)
    alu_flags.update && !reg_wr |=>
      ps_q[arch_state_pkg::PS_ZERO] == ($past(alu_flags.result) == arch_state_pkg::WORD_ZERO)
      && ps_q[arch_state_pkg::PS_NEGATIVE] == $past(alu_flags.result[31]))
    else $error("zero or negative flag does not match the result");

  a_carry_overflow: assert property (
    @(posedge clk) disable iff (sys_rst)
    alu_flags.update && !reg_wr |=>
      ps_q[arch_state_pkg::PS_CARRY] == $past(alu_flags.carry)
      && ps_q[arch_state_pkg::PS_OVERFLOW] == $past(alu_flags.overflow))
    else $error("carry or overflow flag does not match the ALU");

  a_irq_permit_gate: assert property (
    @(posedge clk) disable iff (sys_rst)
    !ps_q[arch_state_pkg::PS_IRQ_PERMIT] |-> !irq_accept)
    else $error("interrupt accepted while not permitted");

  a_irq_level_cmp: assert property (
    @(posedge clk) disable iff (sys_rst)
    irq_req && ps_q[arch_state_pkg::PS_IRQ_PERMIT] |->
      irq_accept == (irq_level < ps_q[arch_state_pkg::PS_LEVEL_MSB:arch_state_pkg::PS_LEVEL_LSB]))
    else $error("interrupt acceptance disagrees with the level mask");

  a_trace_trap_pulse: assert property (
    @(posedge clk) disable iff (sys_rst)
    instr_retire ##1 trace_trap |-> $past(ps_q[arch_state_pkg::PS_STEP_TRACE]))
    else $error("step trace trap raised while trace disabled");

  a_direct_range: assert property (
    @(posedge clk) disable iff (sys_rst)
    direct_size == arch_state_pkg::SIZE_WORD |=>
      direct_in_range && direct_addr <= arch_state_pkg::DIRECT_WORD_LIMIT && direct_addr[1:0] == 2'h0)
    else $error("direct word address outside its area");

  a_muldiv_capture: assert property (
    @(posedge clk) disable iff (sys_rst)
    muldiv_write.enable |=> mdh_q == $past(muldiv_write.high) && mdl_q == $past(muldiv_write.low))
    else $error("multiply result pair not captured");

  a_read_port_timing: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == arch_state_pkg::REG_PROGRAM_STATUS |=> reg_rdata == $past(ps_q))
    else $error("program status read data wrong");

  // Read data must fall back to zero in any cycle that does not follow a read strobe.
  a_rdata_idle_zero: assert property (
    @(posedge clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == arch_state_pkg::WORD_ZERO)
    else $error("read data not zero without a read strobe");

  a_trap_needs_retire: assert property (
    @(posedge clk) disable iff (sys_rst)
    !instr_retire |=> !trace_trap)
    else $error("step trace trap raised without a retired instruction");

endmodule

// *** pipeline_model.sv ***
`timescale 1ns/1ps
module pipeline_model (
  input wire logic clk,
  input wire logic [31:0] read_a_data,
  input wire logic [31:0] read_b_data,
  output arch_state_pkg::gpr_write_type gpr_write,
  output logic [3:0] read_a_index,
  output logic [3:0] read_b_index,
  output arch_state_pkg::alu_flags_type alu_flags,
  output arch_state_pkg::muldiv_write_type muldiv_write,
  output logic instr_retire
);
  initial begin
    gpr_write = '0;
    read_a_index = 4'h0;
    read_b_index = 4'h0;
    alu_flags = '0;
    muldiv_write = '0;
    instr_retire = 1'b0;
  end
  // Released fields carry the inverse of the last value so stale data cannot pass for fresh.
  task put_gpr(input logic [3:0] idx, input logic [31:0] v);
    @(posedge clk);
    gpr_write <= {1'b1, idx, v};
    @(posedge clk);
    gpr_write <= {1'b0, ~idx, ~v};
  endtask
  task get_gpr(input logic [3:0] ia, input logic [3:0] ib, output logic [31:0] da, output logic [31:0] db);
    @(posedge clk);
    read_a_index <= ia;
    read_b_index <= ib;
    @(posedge clk);
    #1;
    da = read_a_data;
    db = read_b_data;
  endtask
  task set_flags(input logic [31:0] res, input logic c, input logic v);
    @(posedge clk);
    alu_flags <= {1'b1, res, c, v};
    @(posedge clk);
    alu_flags <= {1'b0, ~res, ~c, ~v};
  endtask
  task put_muldiv(input logic [31:0] hi, input logic [31:0] lo);
    @(posedge clk);
    muldiv_write <= {1'b1, hi, lo};
    @(posedge clk);
    muldiv_write <= {1'b0, ~hi, ~lo};
  endtask
  task retire();
    @(posedge clk);
    instr_retire <= 1'b1;
    @(posedge clk);
    instr_retire <= 1'b0;
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic clk, sys_rst, reg_wr, reg_rd, ip_load, rp_load, irq_req, direct_in_range, instr_retire, trace_trap, irq_accept;
  logic [3:0] reg_addr, read_a_index, read_b_index;
  logic [31:0] reg_wdata, reg_rdata, ip_next, rp_next, direct_addr, instruction_pointer, vector_table_base;
  logic [31:0] return_pointer, program_status, read_a_data, read_b_data, got, gb, d;
  logic [7:0] direct_field;
  logic [4:0] irq_level;
  arch_state_pkg::access_size_type direct_size;
  arch_state_pkg::gpr_write_type gpr_write;
  arch_state_pkg::alu_flags_type alu_flags;
  arch_state_pkg::muldiv_write_type muldiv_write;
  logic [31:0] m [0:8];
  logic [31:0] g [0:15];
  integer errors = 0, checked = 0, seed = 32'h0bc3c643, i, k;
  cpu_arch_state uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .read_a_index(read_a_index), .read_b_index(read_b_index),
    .read_a_data(read_a_data), .read_b_data(read_b_data), .gpr_write(gpr_write), .ip_load(ip_load),
    .ip_next(ip_next), .rp_load(rp_load), .rp_next(rp_next), .alu_flags(alu_flags), .muldiv_write(muldiv_write),
    .direct_field(direct_field), .direct_size(direct_size), .direct_addr(direct_addr),
    .direct_in_range(direct_in_range), .instr_retire(instr_retire), .trace_trap(trace_trap), .irq_req(irq_req),
    .irq_level(irq_level), .irq_accept(irq_accept), .instruction_pointer(instruction_pointer),
    .vector_table_base(vector_table_base), .return_pointer(return_pointer), .program_status(program_status));
  pipeline_model pipe (.clk(clk), .read_a_data(read_a_data), .read_b_data(read_b_data), .gpr_write(gpr_write),
    .read_a_index(read_a_index), .read_b_index(read_b_index), .alu_flags(alu_flags), .muldiv_write(muldiv_write),
    .instr_retire(instr_retire));
  ////////////////////////////////////////////////////////////////////////////////
  task complete_run();
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got_v, input logic [31:0] exp_v, input string msg);
    checked++;
    if (got_v !== exp_v) begin
      $display("wrong value at %0t: %s", $time, msg);
      errors++;
    end
  endtask
  function logic [31:0] mexp(input logic [3:0] a);
    if (a == 4'h8) return {27'h0, m[1][20:16]};
    return (a < 4'h8) ? m[a] : 32'h0;
  endfunction
  function logic [31:0] gexp(input logic [3:0] a);
    if (a != 4'hf) return g[a];
    return m[1][5] ? m[5] : m[4];
  endfunction
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == 4'h1) m[1] = v & arch_state_pkg::PS_WRITABLE;
    else if (a == 4'h8) m[1][20:16] = v[4:0];
    else if (a < 4'h8) m[a] = v;
  endtask
  task rdchk(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, mexp(a), "register read");
    @(posedge clk);
    #1 chk(reg_rdata, 32'h0, "read data idle");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    errors++;
    complete_run();
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, ip_load, rp_load, irq_req} = 6'h21;
    {reg_addr, reg_wdata, ip_next, rp_next, direct_field, irq_level} = '0;
    direct_size = arch_state_pkg::SIZE_BYTE;
    for (k = 0; k < 9; k++) m[k] = 32'h0;
    m[1] = arch_state_pkg::PS_RESET;
    m[2] = arch_state_pkg::VECTOR_BASE_RESET;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 10; k++) rdchk(k[3:0]);
    pipe.get_gpr(4'hf, 4'hf, got, gb);
    chk(got, 32'h0, "stack register after reset");
    for (k = 0; k < 10; k++) wr(k[3:0], $random(seed));
    for (k = 0; k < 10; k++) rdchk(k[3:0]);
    for (i = 0; i < 2; i++) begin
      wr(4'h1, i << 5);
      for (k = 0; k < 16; k++) begin
        d = $random(seed);
        pipe.put_gpr(k[3:0], d);
        if (k < 15) g[k] = d;
        else m[i ? 5 : 4] = d;
      end
      for (k = 0; k < 16; k++) begin
        pipe.get_gpr(k[3:0], 4'(15 - k), got, gb);
        chk(got, gexp(k[3:0]), "general port a");
        chk(gb, gexp(4'(15 - k)), "general port b");
      end
      rdchk(4'h4);
      rdchk(4'h5);
    end
    for (k = 0; k < 8; k++) begin
      d = (k < 2) ? 32'h0 : (k < 4) ? 32'h80000000 : $random(seed);
      pipe.set_flags(d, k[0], k[1]);
      m[1][3:0] = {d[31], d == 32'h0, k[1], k[0]};
      #1 chk(program_status, m[1], "condition flags");
    end
    for (k = 0; k < 4; k++) begin
      wr(4'h1, ($random(seed) & 32'h001f0000) | (k[0] << 4));
      for (i = 0; i < 32; i++) begin
        @(posedge clk);
        irq_req <= 1'b1;
        irq_level <= i[4:0];
        #1 chk(irq_accept, k[0] && (i < m[1][20:16]), "interrupt acceptance");
      end
    end
    @(posedge clk);
    irq_req <= 1'b0;
    #1 chk(irq_accept, 1'b0, "no request accepted");
    for (k = 0; k < 2; k++) begin
      wr(4'h1, k << 8);
      pipe.retire();
      #1 chk(trace_trap, k[0], "trace trap");
      @(posedge clk);
      #1 chk(trace_trap, 1'b0, "trace trap pulse");
    end
    for (k = 0; k < 12; k++) begin
      d = (k < 3) ? 32'hff : $random(seed);
      @(posedge clk);
      direct_field <= d[7:0];
      direct_size <= arch_state_pkg::access_size_type'(k % 3);
      @(posedge clk);
      #1 chk(direct_addr, {24'h0, d[7:0]} << (k % 3), "direct address");
      chk(direct_in_range, 1'b1, "direct range");
    end
    d = $random(seed);
    @(posedge clk);
    ip_load <= 1'b1;
    ip_next <= d;
    rp_load <= 1'b1;
    rp_next <= ~d;
    @(posedge clk);
    ip_load <= 1'b0;
    rp_load <= 1'b0;
    #1 chk(instruction_pointer, d, "instruction pointer load");
    chk(return_pointer, ~d, "return pointer load");
    chk(vector_table_base, m[2], "vector base");
    pipe.put_muldiv(d, ~d);
    m[6] = d;
    m[7] = ~d;
    rdchk(4'h6);
    rdchk(4'h7);
    complete_run();
  end
endmodule
